// file: logic/dmarx_pkg.sv
package dmarx_pkg;
    // Register indices on the control-register port
    localparam logic [1:0] REG_CHANNEL_CONTROL = 2'h0;
    localparam logic [1:0] REG_INTERRUPT_STATE = 2'h1;
    localparam logic [1:0] REG_DESC_STATUS     = 2'h2;
    localparam logic [1:0] REG_ENGINE_CONTROL  = 2'h3;

    // Channel control fields
    localparam int CTL_COALESCE_EN   = 31;
    localparam int CTL_DELAY_EN      = 30;
    localparam int CTL_ERROR_EN      = 29;
    localparam int CTL_MASTER_EN     = 24;
    localparam int CTL_LOAD_COUNTER  = 23;
    localparam int CTL_SEL_INT_ON_END = 22;
    localparam int CTL_SINGLE_BIT    = 21;
    localparam int CTL_APP_MASK_EN   = 20;
    localparam int CTL_UPPER_ADDR_LSB = 16;
    localparam int CTL_PRELOAD_LSB   = 8;
    localparam int CTL_TIMEOUT_LSB   = 0;
    localparam logic [31:0] CTL_RESET      = 32'h0000_0000;
    localparam logic [31:0] CTL_STORE_MASK = 32'he17f_ffff;

    // Interrupt state fields
    localparam int IRQ_COALESCE_PEND = 31;
    localparam int IRQ_DELAY_PEND    = 30;
    localparam int IRQ_ERROR_PEND    = 29;
    localparam int IRQ_WRITE_FAULT   = 28;
    localparam int IRQ_READ_FAULT    = 27;
    localparam int IRQ_DELAY_CNT_LSB = 22;
    localparam int IRQ_COAL_CNT_LSB  = 18;
    localparam int IRQ_WQ_EMPTY      = 17;
    localparam int IRQ_COAL_NOW_LSB  = 8;
    localparam int IRQ_TIMER_NOW_LSB = 0;

    // Descriptor status fields
    localparam int STS_CHANNEL_ACTIVE = 31;
    localparam int STS_CHAIN_ACTIVE   = 30;
    localparam int STS_EOP            = 29;
    localparam int STS_SOP            = 28;
    localparam int STS_COMPLETED      = 27;
    localparam int STS_HALT_AFTER     = 26;
    localparam int STS_IRQ_AFTER      = 25;
    localparam int STS_ERROR          = 24;

    // Engine control field
    localparam int ENG_SOFT_RESET = 31;

    // Counter limits
    localparam logic [3:0] COAL_OUT_MAX  = 4'hf;
    localparam logic [1:0] DELAY_OUT_MAX = 2'h3;
    localparam logic [23:0] WORD_BYTES   = 24'h00_0004;

    // Delay timer advances once per this many engine clocks
    localparam int DELAY_TICK_CYCLES = 64;
endpackage : dmarx_pkg

// file: logic/dmarx_irq_status.sv
`timescale 1ns/10ps
// Summary of operation
// - Separate coalesce, delay, error mechanism enables
// - Master enable gates receive interrupt output
// - Load bit preloads coalescing counter, self-clears
// - Select counts interrupt-on-end or end-of-packet
// - Single-bit option limits outstanding counters
// - Coalescing counter reloads from preload at zero
// - Delay timer equal timeout raises event
// - Interrupt is OR of pending, masked by master
// - Coalesce pending while counter nonzero; ack decrements
// - Delay pending while counter nonzero; ack decrements
// - Error pending sets on error, ack clears
// - Bus faults set fault bits, freeze link
// - Fault bits clear only by hard/soft reset
// - Interrupt register shows debug counters
// - Read-only write queue empty status bit
// - Channel busy clears when flushed and idle
// - Chain busy while descriptors remain
// - Link start/end of packet set descriptor flags
// - Completed on length zero or end of packet
// - Halt channel after stop-on-end descriptor
// - Interrupt-on-end descriptor raises interrupt event
// - Soft reset bit self-clears after flush

module dmarx_fifo #(
    parameter int WIDTH = 34,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             reset_n,
    input  wire logic             flush,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data,
    // Status
    output logic                  empty
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    assign in_ready  = (count_r != (AW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign empty     = (count_r == '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr_r];

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else if (flush) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= AW'(wr_ptr_r + 1'b1);
            end
            if (pop) begin
                rd_ptr_r <= AW'(rd_ptr_r + 1'b1);
            end
            count_r <= (AW+1)'(count_r + push - pop);
        end
    end
endmodule : dmarx_fifo

module dmarx_irq_status #(
    parameter int FIFO_DEPTH  = 16,
    parameter int TICK_CYCLES = dmarx_pkg::DELAY_TICK_CYCLES
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset_n,
    // Control-register port
    input  wire logic [1:0]  reg_addr,
    input  wire logic        reg_wr_en,
    input  wire logic        reg_rd_en,
    input  wire logic [31:0] reg_wdata,
    output logic      [31:0] reg_rdata,
    output logic             reg_ack,
    // Receive stream link
    input  wire logic [31:0] rx_data,
    input  wire logic        rx_sop_n,
    input  wire logic        rx_eop_n,
    input  wire logic        rx_src_rdy_n,
    output logic             rx_dst_rdy_n,
    // Memory write side
    output logic             mem_wr_valid,
    input  wire logic        mem_wr_ready,
    output logic      [31:0] mem_wr_data,
    input  wire logic        write_queue_empty,
    input  wire logic        bus_read_fault,
    input  wire logic        bus_write_fault,
    // Descriptor handling
    input  wire logic        desc_load,
    input  wire logic [23:0] desc_length,
    input  wire logic        desc_halt_after,
    input  wire logic        desc_irq_after,
    input  wire logic        desc_remaining,
    output logic             desc_done,
    input  wire logic        rx_error,
    // Engine outputs
    output logic             rx_irq,
    output logic             channel_halted,
    output logic             engine_reset_ack
);
    import dmarx_pkg::*;

    logic [31:0] ctl_r;
    logic        completed_r, sop_r, eop_r;
    logic        halt_after_r, irq_after_r;
    logic        desc_active_r, halted_r;
    logic [23:0] remain_r;
    logic [7:0]  coal_now_r;
    logic [7:0]  timer_now_r;
    logic        timer_armed_r;
    logic [3:0]  coal_out_r;
    logic [1:0]  delay_out_r;
    logic        error_pend_r, rd_fault_r, wr_fault_r;
    logic        soft_reset_r;
    logic [$clog2(TICK_CYCLES+1)-1:0] tick_cnt_r;
    logic        tick;
    logic        load_pulse;
    logic        wr_ctl, wr_irq, wr_sts, wr_eng;
    logic        freeze, fifo_empty, fifo_in_ready, fifo_out_valid;
    logic        drain, last_word, coal_event, coal_fire, delay_fire;
    logic [33:0] fifo_out;
    logic [31:0] irq_word, sts_word;

    function automatic logic reg_hit(input logic [1:0] a,
                                     input logic [1:0] idx);
        reg_hit = reg_wr_en && (a == idx);
    endfunction : reg_hit

    assign wr_ctl = reg_hit(reg_addr, REG_CHANNEL_CONTROL);
    assign wr_irq = reg_hit(reg_addr, REG_INTERRUPT_STATE);
    assign wr_sts = reg_hit(reg_addr, REG_DESC_STATUS);
    assign wr_eng = reg_hit(reg_addr, REG_ENGINE_CONTROL);
    assign load_pulse = wr_ctl && reg_wdata[CTL_LOAD_COUNTER];

    // Control register; load bit is never stored
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ctl_r <= CTL_RESET;
        end else if (wr_ctl) begin
            ctl_r <= reg_wdata & CTL_STORE_MASK;
        end
    end

    // Engine soft reset: held until queues are flushed
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            soft_reset_r <= 1'b0;
        end else if (wr_eng && reg_wdata[ENG_SOFT_RESET]) begin
            soft_reset_r <= 1'b1;
        end else if (fifo_empty && write_queue_empty) begin
            soft_reset_r <= 1'b0;
        end
    end
    assign engine_reset_ack = soft_reset_r;

    // Bus faults freeze the link
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rd_fault_r <= 1'b0;
            wr_fault_r <= 1'b0;
        end else if (soft_reset_r) begin
            rd_fault_r <= 1'b0;
            wr_fault_r <= 1'b0;
        end else begin
            rd_fault_r <= rd_fault_r | bus_read_fault;
            wr_fault_r <= wr_fault_r | bus_write_fault;
        end
    end
    assign freeze = rd_fault_r || wr_fault_r || bus_read_fault
                    || bus_write_fault;

    // Link into buffer; sop and eop travel with each word
    assign rx_dst_rdy_n = !(fifo_in_ready && !freeze && !halted_r
                            && !soft_reset_r);
    assign drain = fifo_out_valid && desc_active_r && !freeze
                   && !halted_r && mem_wr_ready;
    assign mem_wr_valid = fifo_out_valid && desc_active_r && !freeze
                          && !halted_r;
    assign mem_wr_data  = fifo_out[31:0];

    dmarx_fifo #(
        .WIDTH (34),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .flush     (soft_reset_r),
        .in_valid  (!rx_src_rdy_n && !rx_dst_rdy_n),
        .in_ready  (fifo_in_ready),
        .in_data   ({!rx_sop_n, !rx_eop_n, rx_data}),
        .out_valid (fifo_out_valid),
        .out_ready (drain),
        .out_data  (fifo_out),
        .empty     (fifo_empty)
    );

    // Descriptor ends on last word or on end of packet
    assign last_word = drain && (fifo_out[32] || remain_r <= WORD_BYTES);
    assign desc_done = last_word;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            desc_active_r <= 1'b0;
            remain_r      <= '0;
            completed_r   <= 1'b0;
            sop_r         <= 1'b0;
            eop_r         <= 1'b0;
            halt_after_r  <= 1'b0;
            irq_after_r   <= 1'b0;
            halted_r      <= 1'b0;
        end else if (soft_reset_r) begin
            desc_active_r <= 1'b0;
            completed_r   <= 1'b0;
            sop_r         <= 1'b0;
            eop_r         <= 1'b0;
            halted_r      <= 1'b0;
        end else if (desc_load) begin
            desc_active_r <= 1'b1;
            remain_r      <= desc_length;
            completed_r   <= 1'b0;
            sop_r         <= 1'b0;
            eop_r         <= 1'b0;
            halt_after_r  <= desc_halt_after;
            irq_after_r   <= desc_irq_after;
            halted_r      <= 1'b0;
        end else begin
            if (drain) begin
                remain_r <= (remain_r > WORD_BYTES) ?
                            24'(remain_r - WORD_BYTES) : '0;
                sop_r <= sop_r | fifo_out[33];
                eop_r <= eop_r | fifo_out[32];
            end
            if (last_word) begin
                desc_active_r <= 1'b0;
                completed_r   <= 1'b1;
                halted_r      <= halt_after_r;
            end
            if (wr_sts) begin
                eop_r        <= reg_wdata[STS_EOP];
                sop_r        <= reg_wdata[STS_SOP];
                completed_r  <= reg_wdata[STS_COMPLETED];
                halt_after_r <= reg_wdata[STS_HALT_AFTER];
                irq_after_r  <= reg_wdata[STS_IRQ_AFTER];
            end
        end
    end
    assign channel_halted = halted_r;

    // Coalescing event source
    assign coal_event = last_word && ctl_r[CTL_COALESCE_EN]
                        && (ctl_r[CTL_SEL_INT_ON_END] ? irq_after_r
                                                      : fifo_out[32]);
    assign coal_fire = coal_event && (coal_now_r <= 8'h01);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            coal_now_r <= '0;
        end else if (load_pulse) begin
            coal_now_r <= reg_wdata[CTL_PRELOAD_LSB +: 8];
        end else if (coal_fire) begin
            coal_now_r <= ctl_r[CTL_PRELOAD_LSB +: 8];
        end else if (coal_event) begin
            coal_now_r <= 8'(coal_now_r - 1'b1);
        end
    end

    // Delay timer tick divider
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tick_cnt_r <= '0;
        end else if (tick) begin
            tick_cnt_r <= '0;
        end else begin
            tick_cnt_r <= $bits(tick_cnt_r)'(tick_cnt_r + 1'b1);
        end
    end
    assign tick = (tick_cnt_r == $bits(tick_cnt_r)'(TICK_CYCLES - 1));

    // Timer runs while events wait for the coalescing count
    assign delay_fire = timer_armed_r && ctl_r[CTL_DELAY_EN]
                        && (ctl_r[CTL_TIMEOUT_LSB +: 8] != 8'h00)
                        && (timer_now_r == ctl_r[CTL_TIMEOUT_LSB +: 8]);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            timer_now_r   <= '0;
            timer_armed_r <= 1'b0;
        end else if (soft_reset_r || coal_fire || delay_fire) begin
            timer_now_r   <= '0;
            timer_armed_r <= 1'b0;
        end else if (coal_event) begin
            timer_now_r   <= '0;
            timer_armed_r <= 1'b1;
        end else if (timer_armed_r && tick) begin
            timer_now_r <= 8'(timer_now_r + 1'b1);
        end
    end

    // Outstanding counters: event and acknowledge in one cycle cancel
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            coal_out_r <= '0;
        end else if (soft_reset_r) begin
            coal_out_r <= '0;
        end else if (coal_fire && !(wr_irq && reg_wdata[IRQ_COALESCE_PEND]
                                    && coal_out_r != '0)) begin
            if (coal_out_r != (ctl_r[CTL_SINGLE_BIT] ? 4'h1 : COAL_OUT_MAX))
                begin
                coal_out_r <= 4'(coal_out_r + 1'b1);
            end
        end else if (!coal_fire && wr_irq && reg_wdata[IRQ_COALESCE_PEND]
                     && coal_out_r != '0) begin
            coal_out_r <= 4'(coal_out_r - 1'b1);
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            delay_out_r <= '0;
        end else if (soft_reset_r) begin
            delay_out_r <= '0;
        end else if (delay_fire && !(wr_irq && reg_wdata[IRQ_DELAY_PEND]
                                     && delay_out_r != '0)) begin
            if (delay_out_r != (ctl_r[CTL_SINGLE_BIT] ? 2'h1 : DELAY_OUT_MAX))
                begin
                delay_out_r <= 2'(delay_out_r + 1'b1);
            end
        end else if (!delay_fire && wr_irq && reg_wdata[IRQ_DELAY_PEND]
                     && delay_out_r != '0) begin
            delay_out_r <= 2'(delay_out_r - 1'b1);
        end
    end

    // Error pending: a new error wins over the acknowledge
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            error_pend_r <= 1'b0;
        end else if (soft_reset_r) begin
            error_pend_r <= 1'b0;
        end else if (rx_error && ctl_r[CTL_ERROR_EN]) begin
            error_pend_r <= 1'b1;
        end else if (wr_irq && reg_wdata[IRQ_ERROR_PEND]) begin
            error_pend_r <= 1'b0;
        end
    end

    assign rx_irq = ctl_r[CTL_MASTER_EN] && ((coal_out_r != '0)
                    || (delay_out_r != '0) || error_pend_r);

    always_comb begin
        irq_word = '0;
        irq_word[IRQ_COALESCE_PEND] = (coal_out_r != '0);
        irq_word[IRQ_DELAY_PEND]    = (delay_out_r != '0);
        irq_word[IRQ_ERROR_PEND]    = error_pend_r;
        irq_word[IRQ_WRITE_FAULT]   = wr_fault_r;
        irq_word[IRQ_READ_FAULT]    = rd_fault_r;
        irq_word[IRQ_DELAY_CNT_LSB +: 2] = delay_out_r;
        irq_word[IRQ_COAL_CNT_LSB +: 4]  = coal_out_r;
        irq_word[IRQ_WQ_EMPTY]           = write_queue_empty;
        irq_word[IRQ_COAL_NOW_LSB +: 8]  = coal_now_r;
        irq_word[IRQ_TIMER_NOW_LSB +: 8] = timer_now_r;
    end

    always_comb begin
        sts_word = '0;
        sts_word[STS_CHANNEL_ACTIVE] = desc_active_r || desc_remaining
                                       || !fifo_empty
                                       || !write_queue_empty;
        sts_word[STS_CHAIN_ACTIVE] = desc_active_r || desc_remaining;
        sts_word[STS_EOP]        = eop_r;
        sts_word[STS_SOP]        = sop_r;
        sts_word[STS_COMPLETED]  = completed_r;
        sts_word[STS_HALT_AFTER] = halt_after_r;
        sts_word[STS_IRQ_AFTER]  = irq_after_r;
        sts_word[STS_ERROR]      = error_pend_r;
    end

    // Read data and acknowledge, one cycle after the strobe
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= '0;
            reg_ack   <= 1'b0;
        end else begin
            reg_ack <= reg_rd_en || reg_wr_en;
            if (reg_rd_en) begin
                unique case (reg_addr)
                    REG_CHANNEL_CONTROL: reg_rdata <= ctl_r;
                    REG_INTERRUPT_STATE: reg_rdata <= irq_word;
                    REG_DESC_STATUS:     reg_rdata <= sts_word;
                    REG_ENGINE_CONTROL:  reg_rdata <= {soft_reset_r, 31'h0};
                endcase
            end
        end
    end
endmodule : dmarx_irq_status

// file: verification/dmarx_irq_status_props.sv
`timescale 1ns/10ps
module dmarx_irq_status_props (
    // Clock and reset
    input logic        mclk,
    input logic        reset_n,
    // Register port
    input logic [1:0]  reg_addr,
    input logic        reg_wr_en,
    input logic        reg_rd_en,
    input logic [31:0] reg_wdata,
    input logic [31:0] reg_rdata,
    input logic        reg_ack,
    // Link, bus and descriptor side
    input logic        rx_dst_rdy_n,
    input logic        write_queue_empty,
    input logic        bus_read_fault,
    input logic        bus_write_fault,
    input logic        desc_load,
    input logic        desc_halt_after,
    input logic        desc_done,
    input logic        rx_error,
    input logic        rx_irq,
    input logic        channel_halted,
    input logic        engine_reset_ack
);
    import dmarx_pkg::*;
    logic [31:0] ctl_r;
    logic        halt_arm_r;
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // Shadow of the channel control word
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            ctl_r <= CTL_RESET;
        else if (reg_wr_en && reg_addr == REG_CHANNEL_CONTROL)
            ctl_r <= reg_wdata;
    end
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            halt_arm_r <= 1'b0;
        else if (desc_load)
            halt_arm_r <= desc_halt_after;
    end
    AST_ACK: assert property (reg_ack == $past(reg_wr_en || reg_rd_en))
        else $error("register answer not one cycle after strobe");
    AST_RDATA: assert property (!reg_rd_en |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    AST_IRQ_OFF: assert property (!ctl_r[CTL_MASTER_EN] |-> !rx_irq)
        else $error("interrupt raised while master enable is off");
    AST_ERR_IRQ: assert property (rx_error && ctl_r[CTL_ERROR_EN] &&
        ctl_r[CTL_MASTER_EN] |=> rx_irq)
        else $error("receive error did not raise the interrupt");
    AST_FREEZE: assert property ((bus_read_fault || bus_write_fault)
        |=> rx_dst_rdy_n[*3])
        else $error("link not frozen after bus fault");
    AST_HALT: assert property (desc_done && halt_arm_r |=> channel_halted)
        else $error("channel did not halt after descriptor");
    AST_HALT_STALL: assert property (channel_halted |-> rx_dst_rdy_n)
        else $error("link accepts data while halted");
    AST_SOFT_ACK: assert property (reg_wr_en &&
        reg_addr == REG_ENGINE_CONTROL && reg_wdata[ENG_SOFT_RESET]
        |=> engine_reset_ack)
        else $error("soft reset not acknowledged");
    AST_SOFT_END: assert property (engine_reset_ack && write_queue_empty
        |-> ##[1:40] !engine_reset_ack)
        else $error("soft reset never finished");
endmodule : dmarx_irq_status_props

// file: verification/dmarx_link_peer.sv
`timescale 1ns/10ps
module dmarx_link_peer (
    // Clock
    input  logic        mclk,
    // Stream link
    output logic [31:0] rx_data,
    output logic        rx_sop_n,
    output logic        rx_eop_n,
    output logic        rx_src_rdy_n,
    input  logic        rx_dst_rdy_n,
    // Memory side
    output logic        mem_wr_ready
);
    logic [1:0] stall_r = 2'h0;
    initial begin
        {rx_sop_n, rx_eop_n, rx_src_rdy_n} = 3'h7;
        rx_data = 32'h0;
    end
    // Memory stalls one cycle in four
    always_ff @(posedge mclk) stall_r <= stall_r + 2'h1;
    assign mem_wr_ready = (stall_r != 2'h0);
    task automatic send(input int nw, input logic eop);
        for (int i = 0; i < nw; i++) begin
            rx_data      <= 32'hc0de_0000 + 32'(i);
            rx_sop_n     <= (i != 0);
            rx_eop_n     <= !(eop && i == nw - 1);
            rx_src_rdy_n <= 1'b0;
            do @(posedge mclk); while (rx_dst_rdy_n !== 1'b0);
        end
        // Released data lines do not keep the last word
        {rx_sop_n, rx_eop_n, rx_src_rdy_n} <= 3'h7;
        rx_data <= ~rx_data;
    endtask : send
endmodule : dmarx_link_peer

// file: verification/dmarx_irq_status_tb.sv
`timescale 1ns/10ps
module dmarx_irq_status_tb;
    import dmarx_pkg::*;
    localparam logic [1:0] RC = REG_CHANNEL_CONTROL;
    localparam logic [1:0] RI = REG_INTERRUPT_STATE;
    localparam logic [1:0] RS = REG_DESC_STATUS;
    logic        mclk, reset_n, reg_wr_en, reg_rd_en, reg_ack;
    logic [1:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rx_data, mem_wr_data;
    logic        rx_sop_n, rx_eop_n, rx_src_rdy_n, rx_dst_rdy_n;
    logic        mem_wr_valid, mem_wr_ready, write_queue_empty;
    logic        bus_read_fault, bus_write_fault, desc_load, rx_error;
    logic        desc_halt_after, desc_irq_after, desc_remaining;
    logic        desc_done, rx_irq, channel_halted, engine_reset_ack;
    logic [23:0] desc_length;
    int          n_mismatch = 0, compares = 0, n_done = 0;
    dmarx_irq_status #(.TICK_CYCLES(2)) uut (
        .mclk, .reset_n, .reg_addr, .reg_wr_en, .reg_rd_en, .reg_wdata,
        .reg_rdata, .reg_ack, .rx_data, .rx_sop_n, .rx_eop_n,
        .rx_src_rdy_n, .rx_dst_rdy_n, .mem_wr_valid, .mem_wr_ready,
        .mem_wr_data, .write_queue_empty, .bus_read_fault,
        .bus_write_fault, .desc_load, .desc_length, .desc_halt_after,
        .desc_irq_after, .desc_remaining, .desc_done, .rx_error, .rx_irq,
        .channel_halted, .engine_reset_ack
    );
    dmarx_link_peer peer (
        .mclk, .rx_data, .rx_sop_n, .rx_eop_n, .rx_src_rdy_n,
        .rx_dst_rdy_n, .mem_wr_ready
    );
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) if (desc_done === 1'b1) n_done++;
    task automatic summarize();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize
    task automatic chk(input string nm, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [1:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr_en <= 1'b1;
        @(posedge mclk);
        reg_wr_en <= 1'b0;
        @(posedge mclk);
    endtask : wr
    task automatic rc(input logic [1:0] a, input logic [31:0] m, e);
        reg_addr  <= a;
        reg_rd_en <= 1'b1;
        @(posedge mclk);
        reg_rd_en <= 1'b0;
        @(posedge mclk);
        chk($sformatf("register %0d", a), e, reg_rdata & m);
    endtask : rc
    task automatic run_desc(input logic [23:0] len, input logic h, ir,
                            input int nw, input logic eop);
        int want;
        want = n_done + 1;
        desc_length     <= len;
        desc_halt_after <= h;
        desc_irq_after  <= ir;
        desc_load       <= 1'b1;
        @(posedge mclk);
        desc_load <= 1'b0;
        peer.send(nw, eop);
        for (int i = 0; i < 200 && n_done < want; i++) @(posedge mclk);
        chk("descriptor done", 32'h1, 32'(n_done >= want));
        repeat (2) @(posedge mclk);
    endtask : run_desc
    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        summarize();
    end
    initial begin
        reset_n = 1'b0;
        {reg_wr_en, reg_rd_en, bus_read_fault, bus_write_fault} = '0;
        {desc_load, desc_halt_after, desc_irq_after, desc_remaining} = '0;
        {reg_addr, reg_wdata, desc_length, rx_error} = '0;
        write_queue_empty = 1'b1;
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        rc(RC, '1, CTL_RESET);
        rc(RI, '1, 32'h0002_0000);
        rc(RS, '1, 32'h0);
        wr(RC, 32'h9f80_0200);
        rc(RC, '1, 32'h8100_0200);
        rc(RI, 32'hffff_ff00, 32'h0002_0200);
        run_desc(24'h40, 1'b0, 1'b0, 3, 1'b1);
        rc(RI, 32'hffff_ff00, 32'h0002_0100);
        run_desc(24'h40, 1'b0, 1'b0, 3, 1'b1);
        rc(RI, 32'hffff_ff00, 32'h8006_0200);
        rc(RS, 32'hff00_0000, 32'h3800_0000);
        chk("irq", 32'h1, 32'(rx_irq));
        wr(RI, 32'h8000_0000);
        rc(RI, 32'hffff_ff00, 32'h0002_0200);
        wr(RC, 32'h81e0_0100);
        for (int k = 0; k < 2; k++) run_desc(24'h8, 1'b0, 1'b1, 2, 1'b0);
        rc(RI, 32'hffff_ff00, 32'h8006_0100);
        rc(RS, 32'hff00_0000, 32'h1a00_0000);
        wr(RI, 32'h8000_0000);
        chk("irq", 32'h0, 32'(rx_irq));
        wr(RC, 32'hc180_0240);
        run_desc(24'h40, 1'b0, 1'b0, 1, 1'b1);
        wr(RI, 32'h8000_0000);
        chk("irq", 32'h0, 32'(rx_irq));
        for (int i = 0; i < 400 && rx_irq !== 1'b1; i++) @(posedge mclk);
        rc(RI, 32'hc0c0_0000, 32'h4040_0000);
        wr(RI, 32'h4000_0000);
        chk("irq", 32'h0, 32'(rx_irq));
        run_desc(24'h40, 1'b1, 1'b0, 1, 1'b1);
        chk("halted", 32'h1, 32'(channel_halted));
        rc(RS, 32'h0400_0000, 32'h0400_0000);
        wr(RC, 32'h2100_0000);
        wr(RI, 32'hc000_0000);
        chk("irq", 32'h0, 32'(rx_irq));
        rx_error <= 1'b1;
        @(posedge mclk);
        rx_error <= 1'b0;
        @(posedge mclk);
        chk("irq", 32'h1, 32'(rx_irq));
        rc(RS, 32'h0100_0000, 32'h0100_0000);
        wr(RC, 32'h2000_0000);
        chk("irq", 32'h0, 32'(rx_irq));
        rc(RI, 32'he000_0000, 32'h2000_0000);
        wr(RI, 32'h2000_0000);
        rc(RI, 32'he000_0000, 32'h0);
        desc_remaining <= 1'b1;
        desc_halt_after <= 1'b0;
        desc_load <= 1'b1;
        @(posedge mclk);
        desc_load <= 1'b0;
        rc(RS, 32'hc000_0000, 32'hc000_0000);
        chk("ready", 32'h0, 32'(rx_dst_rdy_n));
        desc_remaining <= 1'b0;
        write_queue_empty <= 1'b0;
        rc(RI, 32'h0002_0000, 32'h0);
        write_queue_empty <= 1'b1;
        bus_write_fault <= 1'b1;
        @(posedge mclk);
        bus_write_fault <= 1'b0;
        bus_read_fault <= 1'b1;
        @(posedge mclk);
        bus_read_fault <= 1'b0;
        wr(RI, 32'h1800_0000);
        rc(RI, 32'h1800_0000, 32'h1800_0000);
        chk("ready", 32'h1, 32'(rx_dst_rdy_n));
        wr(REG_ENGINE_CONTROL, 32'h8000_0000);
        for (int i = 0; i < 50 && engine_reset_ack !== 1'b0; i++)
            @(posedge mclk);
        rc(REG_ENGINE_CONTROL, 32'h8000_0000, 32'h0);
        rc(RI, 32'hf800_0000, 32'h0);
        chk("ready", 32'h0, 32'(rx_dst_rdy_n));
        summarize();
    end
endmodule : dmarx_irq_status_tb
bind dmarx_irq_status dmarx_irq_status_props chk_i (
    .mclk, .reset_n, .reg_addr, .reg_wr_en, .reg_rd_en, .reg_wdata,
    .reg_rdata, .reg_ack, .rx_dst_rdy_n, .write_queue_empty,
    .bus_read_fault, .bus_write_fault, .desc_load, .desc_halt_after,
    .desc_done, .rx_error, .rx_irq, .channel_halted, .engine_reset_ack
);
